// ---- design/led_cfg_pkg.sv ----
// constants and types for the seven-segment driver configuration block
package led_cfg_pkg;

    // serial command word layout, most significant bit first on the link
    localparam int CMD_W = 16;

    typedef struct packed
    {
        logic [3:0] mode;
        logic [3:0] sel;
        logic [3:0] hi;
        logic [3:0] lo;
    } cmd_t;

    // operating-mode field codes
    localparam logic [3:0] MODE_BLANK = 4'h0;
    localparam logic [3:0] MODE_NORMAL = 4'h1;
    localparam logic [3:0] MODE_LOAD = 4'h2;
    localparam logic [3:0] MODE_STANDBY = 4'h4;

    // register selector codes
    localparam logic [3:0] SEL_DUTY = 4'h0;
    localparam logic [3:0] SEL_DECODE_DIGITS = 4'h1;

    // standby sub-codes
    localparam logic [3:0] STBY_HOLD = 4'h0;
    localparam logic [3:0] STBY_CLEAR = 4'h1;

    // decode field codes
    localparam logic [3:0] DECODE_OFF = 4'h0;
    localparam logic [3:0] DECODE_ON = 4'h1;

    // highest legal digit-count code
    localparam logic [3:0] DIGIT_CODE_MAX = 4'h3;

    typedef struct packed
    {
        logic [3:0] duty;
        logic [1:0] last_digit;
        logic decode;
    } cfg_t;

    localparam logic [3:0] DUTY_RESET = 4'hF;
    localparam logic [1:0] LAST_DIGIT_RESET = 2'h3;
    localparam logic DECODE_RESET = 1'b1;
    localparam cfg_t CFG_RESET = '{duty: DUTY_RESET, last_digit: LAST_DIGIT_RESET,
                                   decode: DECODE_RESET};

    // display geometry
    localparam int NUM_DIGITS = 4;
    localparam int SEG_W = 8;
    localparam int DUTY_STEPS = 16;

    // scan timing: one duty sub-step of a digit slot
    localparam int CLK_MHZ = 125;
    localparam int SUBSTEP_NS = 1000;
    localparam int SUBSTEP_CYCLES_RAW = (SUBSTEP_NS * CLK_MHZ) / 1000;
    localparam int SUBSTEP_CYCLES = (SUBSTEP_CYCLES_RAW < 1) ? 1 : SUBSTEP_CYCLES_RAW;

endpackage

// ---- design/led_cfg_top.sv ----
// serial command interpreter, settings store and digit scanner of the LED driver
//
// Summary of operation
// R1: command 20h loads low nibble into duty
// R2: sixteen duty steps, n/16 on-time, zero off
// R3: duty is 15/16 after reset and clear
// R4: duty load ignores command bits 7 to 4
// R5: settings hold until load, reset or clear
// R6: command 21h low nibble selects 1-4 digits
// R7: digit count defaults to four, clear restores
// R8: host sends decode and count together always
// R9: 21h bits 7-4: zero pass, one decodes
// R10: no-decode: data bit n drives segment n
// R11: decode mode is default and after clear
// R12: host picks no-decode for discrete LED use
// R13: bits 15-12 mode, bits 11-8 register select
// R14: all-data-clear returns every setting to default
// R15: standby blanks outputs, hold code keeps every setting
// R16: round-robin scan, digit on for duty fraction
// R17: act after 16 bits, update in one cycle
`timescale 1ns/10ps

module led_cfg_top
#(
    parameter int STEP_CYCLES = led_cfg_pkg::SUBSTEP_CYCLES
)
(
    // system clock and reset
    input wire logic CLK,
    input wire logic RST,
    // serial command link
    input wire logic SCLK,
    input wire logic SEL_N,
    input wire logic SDATA,
    // display data, one byte per digit, digit 0 in the low byte
    input wire logic [led_cfg_pkg::NUM_DIGITS*led_cfg_pkg::SEG_W-1:0] DISPLAY_DATA,
    // display outputs
    output logic [led_cfg_pkg::NUM_DIGITS-1:0] DIGIT_DRIVE_OUTPUTS,
    output logic [led_cfg_pkg::SEG_W-1:0] SEGMENT_BITS,
    output logic DECODE_EN,
    output logic [1:0] ACTIVE_DIGIT
);

    typedef enum logic {DISP_OFF, DISP_ON} disp_t;

    // link domain
    logic [3:0] bit_cnt_q;
    logic [led_cfg_pkg::CMD_W-1:0] shift_q;
    logic [led_cfg_pkg::CMD_W-1:0] hold_q;
    logic word_tog_q;

    // system domain
    logic tog_s1_q;
    logic tog_s2_q;
    logic tog_seen_q;
    logic word_stb;
    led_cfg_pkg::cmd_t cmd_q;
    logic cmd_vld_q;
    led_cfg_pkg::cfg_t cfg_q;
    disp_t disp_q;
    logic [15:0] step_cnt_q;
    logic [3:0] phase_q;
    logic [1:0] digit_q;
    logic step_end;
    logic [led_cfg_pkg::NUM_DIGITS-1:0] drive_d;
    logic [led_cfg_pkg::SEG_W-1:0] cur_byte;

    function automatic logic [led_cfg_pkg::NUM_DIGITS-1:0] digit_onehot(input logic [1:0] idx);
        logic [led_cfg_pkg::NUM_DIGITS-1:0] v;
        v = '0;
        v[idx] = 1'b1;
        return v;
    endfunction

    function automatic logic [led_cfg_pkg::SEG_W-1:0] digit_byte(
        input logic [led_cfg_pkg::NUM_DIGITS*led_cfg_pkg::SEG_W-1:0] data,
        input logic [1:0] idx);
        return data[idx*led_cfg_pkg::SEG_W +: led_cfg_pkg::SEG_W];
    endfunction

    // bit counter restarts whenever the frame select is released
    always_ff @(posedge SCLK or posedge SEL_N)
    begin
        if (SEL_N)
            bit_cnt_q <= 4'h0;
        else
            bit_cnt_q <= bit_cnt_q + 4'h1;
    end

    always_ff @(posedge SCLK)
    begin
        shift_q <= {shift_q[led_cfg_pkg::CMD_W-2:0], SDATA};
    end

    // the word is published only on the sixteenth bit, so a short frame is dropped
    always_ff @(posedge SCLK)
    begin
        if (!SEL_N && bit_cnt_q == 4'hF) // R17
            hold_q <= {shift_q[led_cfg_pkg::CMD_W-2:0], SDATA};
    end

    always_ff @(posedge SCLK or posedge RST)
    begin
        if (RST)
            word_tog_q <= 1'b0;
        else if (!SEL_N && bit_cnt_q == 4'hF)
            word_tog_q <= ~word_tog_q;
    end

    // toggle crossing; hold_q is stable for a whole frame after each toggle
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            tog_s1_q <= 1'b0;
            tog_s2_q <= 1'b0;
            tog_seen_q <= 1'b0;
        end
        else
        begin
            tog_s1_q <= word_tog_q;
            tog_s2_q <= tog_s1_q;
            tog_seen_q <= tog_s2_q;
        end
    end

    assign word_stb = tog_s2_q ^ tog_seen_q;

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            cmd_q <= '0;
            cmd_vld_q <= 1'b0;
        end
        else
        begin
            cmd_vld_q <= word_stb;
            if (word_stb)
                cmd_q <= hold_q;
        end
    end

    // settings store: each command acts in a single clock edge
    always_ff @(posedge CLK)
    begin
        if (RST)
            cfg_q <= led_cfg_pkg::CFG_RESET; // R3 R7 R11
        else if (cmd_vld_q) // R17 R5
        begin
            case (cmd_q.mode) // R13
                led_cfg_pkg::MODE_LOAD:
                begin
                    if (cmd_q.sel == led_cfg_pkg::SEL_DUTY)
                        cfg_q.duty <= cmd_q.lo; // R1 R4
                    else if (cmd_q.sel == led_cfg_pkg::SEL_DECODE_DIGITS)
                    begin
                        if (cmd_q.lo <= led_cfg_pkg::DIGIT_CODE_MAX)
                            cfg_q.last_digit <= cmd_q.lo[1:0]; // R6
                        if (cmd_q.hi == led_cfg_pkg::DECODE_ON)
                            cfg_q.decode <= 1'b1; // R9
                        else if (cmd_q.hi == led_cfg_pkg::DECODE_OFF)
                            cfg_q.decode <= 1'b0; // R9
                    end
                end
                led_cfg_pkg::MODE_STANDBY:
                begin
                    if (cmd_q.lo == led_cfg_pkg::STBY_CLEAR)
                        cfg_q <= led_cfg_pkg::CFG_RESET; // R14 R3 R7 R11
                end
                default:
                begin
                    cfg_q <= cfg_q; // R5
                end
            endcase
        end
    end

    // display on/off state
    always_ff @(posedge CLK)
    begin
        if (RST)
            disp_q <= DISP_OFF;
        else if (cmd_vld_q)
        begin
            case (cmd_q.mode)
                led_cfg_pkg::MODE_NORMAL:
                    disp_q <= DISP_ON;
                led_cfg_pkg::MODE_BLANK:
                    disp_q <= DISP_OFF;
                led_cfg_pkg::MODE_STANDBY:
                    disp_q <= DISP_OFF; // R15
                default:
                    disp_q <= disp_q;
            endcase
        end
    end

    // scan timing: each digit slot has sixteen duty sub-steps
    assign step_end = (step_cnt_q == 16'(STEP_CYCLES - 1));

    always_ff @(posedge CLK)
    begin
        if (RST || step_end)
            step_cnt_q <= 16'h0000;
        else
            step_cnt_q <= step_cnt_q + 16'h0001;
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
            phase_q <= 4'h0;
        else if (step_end)
            phase_q <= phase_q + 4'h1; // R2
    end

    // round-robin digit pointer; a smaller count takes effect at once
    always_ff @(posedge CLK)
    begin
        if (RST)
            digit_q <= 2'h0;
        else if (digit_q > cfg_q.last_digit)
            digit_q <= 2'h0; // R16
        else if (step_end && phase_q == 4'hF)
        begin
            if (digit_q == cfg_q.last_digit)
                digit_q <= 2'h0; // R16 R6
            else
                digit_q <= digit_q + 2'h1; // R16
        end
    end

    always_comb
    begin
        drive_d = '0;
        if (disp_q == DISP_ON && digit_q <= cfg_q.last_digit && phase_q < cfg_q.duty)
            drive_d = digit_onehot(digit_q); // R2 R16
    end

    assign cur_byte = digit_byte(DISPLAY_DATA, digit_q);

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            DIGIT_DRIVE_OUTPUTS <= '0;
            SEGMENT_BITS <= '0;
            ACTIVE_DIGIT <= 2'h0;
        end
        else
        begin
            DIGIT_DRIVE_OUTPUTS <= drive_d;
            ACTIVE_DIGIT <= digit_q;
            if (disp_q == DISP_ON)
                SEGMENT_BITS <= cur_byte; // R10
            else
                SEGMENT_BITS <= '0; // R15
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
            DECODE_EN <= led_cfg_pkg::DECODE_RESET;
        else
            DECODE_EN <= cfg_q.decode; // R9 R11
    end

    // checks

    sequence seq_duty_cmd;
        cmd_vld_q && cmd_q.mode == led_cfg_pkg::MODE_LOAD && cmd_q.sel == led_cfg_pkg::SEL_DUTY;
    endsequence

    sequence seq_dd_cmd;
        cmd_vld_q && cmd_q.mode == led_cfg_pkg::MODE_LOAD
            && cmd_q.sel == led_cfg_pkg::SEL_DECODE_DIGITS;
    endsequence

    sequence seq_clear_cmd;
        cmd_vld_q && cmd_q.mode == led_cfg_pkg::MODE_STANDBY
            && cmd_q.lo == led_cfg_pkg::STBY_CLEAR;
    endsequence

    sequence seq_hold_cmd;
        cmd_vld_q && cmd_q.mode == led_cfg_pkg::MODE_STANDBY
            && cmd_q.lo == led_cfg_pkg::STBY_HOLD;
    endsequence

    chk_duty_load: assert property (@(posedge CLK) disable iff (RST) // R1 R4
        seq_duty_cmd |=> cfg_q.duty == $past(cmd_q.lo))
        else $error("duty not loaded from low nibble");

    chk_duty_reset: assert property (@(posedge CLK) // R3
        RST |=> cfg_q.duty == 4'hF && cfg_q.last_digit == 2'h3 && cfg_q.decode)
        else $error("settings not at defaults after reset");

    chk_clear_all: assert property (@(posedge CLK) disable iff (RST) // R14 R7 R11
        seq_clear_cmd |=> cfg_q.duty == 4'hF && cfg_q.last_digit == 2'h3 && cfg_q.decode == 1'b1)
        else $error("clear did not restore defaults");

    chk_cfg_hold: assert property (@(posedge CLK) disable iff (RST) // R5 R17
        !cmd_vld_q |=> $stable(cfg_q))
        else $error("settings changed without a command");

    chk_digit_load: assert property (@(posedge CLK) disable iff (RST) // R6
        (seq_dd_cmd and (cmd_q.lo <= 4'h3)) |=> cfg_q.last_digit == $past(cmd_q.lo[1:0]))
        else $error("digit count not loaded");

    chk_decode_load: assert property (@(posedge CLK) disable iff (RST) // R9
        (seq_dd_cmd and (cmd_q.hi <= 4'h1)) |=> ##1 DECODE_EN == $past(cmd_q.hi[0], 2))
        else $error("decode flag not loaded");

    chk_standby_keep: assert property (@(posedge CLK) disable iff (RST) // R15
        seq_hold_cmd |=> $stable(cfg_q) && disp_q == DISP_OFF ##1 DIGIT_DRIVE_OUTPUTS == '0)
        else $error("standby lost settings or left outputs on");

    chk_duty_zero: assert property (@(posedge CLK) disable iff (RST) // R2
        cfg_q.duty == 4'h0 |=> DIGIT_DRIVE_OUTPUTS == '0)
        else $error("digit driven at zero duty");

    chk_duty_frac: assert property (@(posedge CLK) disable iff (RST) // R2 R16
        (disp_q == DISP_ON && digit_q <= cfg_q.last_digit && phase_q < cfg_q.duty)
            |=> DIGIT_DRIVE_OUTPUTS == digit_onehot($past(digit_q)))
        else $error("digit not driven inside its duty window");

    chk_digit_range: assert property (@(posedge CLK) disable iff (RST) // R16 R6
        $onehot0(DIGIT_DRIVE_OUTPUTS) && (ACTIVE_DIGIT <= $past(cfg_q.last_digit)
            || DIGIT_DRIVE_OUTPUTS == '0))
        else $error("digit drive outside enabled range");

    chk_seg_pass: assert property (@(posedge CLK) disable iff (RST) // R10
        (disp_q == DISP_ON && !cfg_q.decode) |=> SEGMENT_BITS == $past(cur_byte))
        else $error("segment bits not passed through");

    chk_word_stb: assert property (@(posedge CLK) disable iff (RST) // R17
        word_stb |=> cmd_vld_q && cmd_q == $past(hold_q) ##1 !cmd_vld_q)
        else $error("command not taken once from the link");

endmodule

// ---- tb/led_host_model.sv ----
// serial host model that frames command words on the link
`timescale 1ns/10ps
module led_host_model
#(
    parameter int HALF_NS = 24
)
(
    // serial command link
    output logic SCLK,
    output logic SEL_N,
    output logic SDATA
);
    initial
    begin
        SCLK = 1'b0;
        SEL_N = 1'b1;
        SDATA = 1'b0;
    end

    // msb first; the clock stands still and the data line is inverted between frames
    task automatic send(input logic [15:0] word, input int nbits, input int gap_ns);
        #(HALF_NS + 3);
        SEL_N = 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            SDATA = word[15 - i];
            #HALF_NS SCLK = 1'b1;
            #HALF_NS SCLK = 1'b0;
        end
        #HALF_NS SEL_N = 1'b1;
        SDATA = ~SDATA;
        #(gap_ns);
    endtask
endmodule

// ---- tb/test_led_driver_duty_digit_decode_cfg.sv ----
// self-checking bench for the LED driver configuration block
`timescale 1ns/10ps
module test_led_driver_duty_digit_decode_cfg;
    localparam int STEP = 2;
    logic clk = 1'b0;
    logic rst = 1'b0;
    logic [31:0] data = 32'h0;
    logic sclk;
    logic sel_n;
    logic sdata;
    logic [3:0] dig;
    logic [7:0] seg;
    logic dec_en;
    logic [1:0] act;
    int num_errors = 0;
    int tests_run = 0;
    int m_duty = 15;
    int m_last = 3;
    int m_dec = 1;
    int m_on = 0;
    int cnt [4];
    int bad;

    always #4 clk = ~clk;

    led_host_model host (.SCLK(sclk), .SEL_N(sel_n), .SDATA(sdata));

    led_cfg_top #(.STEP_CYCLES(STEP)) dut
    (
        .CLK(clk), .RST(rst), .SCLK(sclk), .SEL_N(sel_n), .SDATA(sdata),
        .DISPLAY_DATA(data), .DIGIT_DRIVE_OUTPUTS(dig), .SEGMENT_BITS(seg),
        .DECODE_EN(dec_en), .ACTIVE_DIGIT(act)
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // sends a word and updates the behavioural settings model
    task automatic cmd(input logic [15:0] w);
        host.send(w, 16, 100);
        @(posedge clk);
        data <= $urandom;
        case (w[15:12])
            4'h0: m_on = 0;
            4'h1: m_on = 1;
            4'h2:
            begin
                if (w[11:8] == 4'h0)
                    m_duty = w[3:0];
                if (w[11:8] == 4'h1 && w[3:0] <= 4'h3)
                    m_last = w[3:0];
                if (w[11:8] == 4'h1 && w[7:4] <= 4'h1)
                    m_dec = w[7:4];
            end
            4'h4:
            begin
                m_on = 0;
                if (w[3:0] == 4'h1)
                begin
                    m_duty = 15;
                    m_last = 3;
                    m_dec = 1;
                end
            end
            default: ;
        endcase
    endtask

    // counts driven cycles per digit over two whole scan rounds
    task automatic measure(input string name);
        int span;
        repeat (300) @(posedge clk);
        span = 2 * (m_last + 1) * 16 * STEP;
        cnt = '{default: 0};
        bad = 0;
        repeat (span)
        begin
            @(negedge clk);
            for (int k = 0; k < 4; k++)
                if (dig[k] === 1'b1)
                begin
                    cnt[k]++;
                    if (seg !== data[8*k +: 8] || act !== k[1:0] || $countones(dig) != 1)
                        bad++;
                end
            if (m_on == 0 && (seg !== 8'h00 || dig !== 4'h0))
                bad++;
        end
        check({name, " decode"}, {31'h0, dec_en}, m_dec);
        for (int k = 0; k < 4; k++)
            check({name, " digit"}, cnt[k], (m_on && k <= m_last) ? 2*m_duty*STEP : 0);
        check({name, " segments"}, bad, 0);
        $display("test %s done", name);
    endtask

    initial
    begin
        repeat (40000) @(posedge clk);
        num_errors++;
        results();
    end

    initial
    begin
        logic [3:0] d;
        void'($urandom(69394));
        // a real rising edge on reset, so the link-side toggle is cleared as well
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        data <= $urandom;
        measure("reset");
        cmd(16'h1000);
        measure("on");
        for (int i = 0; i < 6; i++)
        begin
            d = (i < 2) ? 4'(i * 15) : 4'($urandom_range(14, 1));
            cmd({8'h20, 4'($urandom), d});
            measure("duty");
        end
        for (int lc = 0; lc < 4; lc++)
        begin
            cmd({8'h21, 4'(lc % 2), 4'(lc)});
            measure("count");
        end
        cmd(16'h2125);
        cmd(16'h2252);
        cmd(16'h3000);
        measure("ignored");
        host.send(16'h2000, 8, 100);
        measure("short");
        cmd(16'h4000);
        measure("standby");
        cmd(16'h1000);
        measure("resume");
        cmd(16'h0000);
        measure("blank");
        cmd(16'h4001);
        measure("clear");
        cmd(16'h1000);
        measure("defaults");
        // second reset in mid-run, with a non-default duty loaded before it
        cmd(16'h2003);
        rst <= 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        m_duty = 15;
        m_on = 0;
        measure("rerun reset");
        cmd(16'h1000);
        measure("rerun on");
        results();
    end
endmodule
